// >>> hw/iq_bridge_pkg.sv
// Constants shared by the sample bus bridge
package iq_bridge_pkg;
  localparam int          BUS_WIDTH      = 8;
  localparam int          CLK_DIV_HALF   = 1;
  localparam logic [7:0]  DAC_RESET_VAL  = 8'h00;
  localparam logic [7:0]  BUS_RESET_VAL  = 8'h00;
  localparam logic        PHASE_I        = 1'b0;
  localparam logic        PHASE_Q        = 1'b1;
endpackage

// >>> hw/iq_sample_bus_bridge.sv
// Bridge between converter samples and an eight bit parallel port
`timescale 1ns/1ps

module iq_sample_bus_bridge #(
  parameter int WIDTH = iq_bridge_pkg::BUS_WIDTH
) (
  input  wire logic             sys_clk_i,
  input  wire logic             srst_i,
  input  wire logic             sample_clk_i,
  input  wire logic [WIDTH-1:0] adc_output_bus_i,
  output logic      [WIDTH-1:0] dac_input_bus_o,
  input  wire logic             direction_rx_i,
  input  wire logic             xfer_enable_i,
  output logic                  xfer_clk_o,
  output logic                  data_valid_o,
  input  wire logic [WIDTH-1:0] data_bus_i,
  output logic      [WIDTH-1:0] data_bus_o,
  output logic      [WIDTH-1:0] data_bus_oe_n_o
);

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  // Pins cross into sys_clk_i through two flops before any use
  logic [2:0] samp_s1_q, samp_s1_d, samp_s2_q, samp_s2_d;
  logic       samp_prev_q, samp_prev_d;
  logic [WIDTH-1:0] adc_s1_q, adc_s1_d, adc_s2_q, adc_s2_d;
  logic [WIDTH-1:0] bus_s1_q, bus_s1_d, bus_s2_q, bus_s2_d;

  always_comb begin
    samp_s1_d   = {xfer_enable_i, direction_rx_i, sample_clk_i};
    samp_s2_d   = samp_s1_q;
    samp_prev_d = samp_s2_q[0];
    adc_s1_d    = adc_output_bus_i;
    adc_s2_d    = adc_s1_q;
    bus_s1_d    = data_bus_i;
    bus_s2_d    = bus_s1_q;
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      samp_s1_q   <= '0;
      samp_s2_q   <= '0;
      samp_prev_q <= 1'b0;
      adc_s1_q    <= '0;
      adc_s2_q    <= '0;
      bus_s1_q    <= '0;
      bus_s2_q    <= '0;
    end else begin
      samp_s1_q   <= samp_s1_d;
      samp_s2_q   <= samp_s2_d;
      samp_prev_q <= samp_prev_d;
      adc_s1_q    <= adc_s1_d;
      adc_s2_q    <= adc_s2_d;
      bus_s1_q    <= bus_s1_d;
      bus_s2_q    <= bus_s2_d;
    end
  end

  logic samp_rise;
  logic samp_fall;
  logic dir_rx;
  logic enable;
  assign samp_rise = samp_s2_q[0] & ~samp_prev_q;
  assign samp_fall = ~samp_s2_q[0] & samp_prev_q;
  assign dir_rx    = samp_s2_q[1];
  assign enable    = samp_s2_q[2];

  // ----------------------------------------
  // Slot decoding
  // ----------------------------------------
  // I rides the rising sample edge, Q the falling one
  function automatic logic slot_of(input logic rise);
    slot_of = rise ? iq_bridge_pkg::PHASE_I : iq_bridge_pkg::PHASE_Q;
  endfunction

  function automatic logic is_i_slot(input logic slot);
    is_i_slot = (slot == iq_bridge_pkg::PHASE_I);
  endfunction

  logic edge_any;
  logic phase_now;

  assign edge_any  = samp_rise | samp_fall;
  assign phase_now = slot_of(samp_rise);

  // ----------------------------------------
  // Transfer clock
  // ----------------------------------------
  // Low for one cycle per sample edge, peripheral samples on rise
  logic clk_q;
  logic clk_d;

  always_comb begin
    clk_d = 1'b1;
    if (edge_any) begin
      clk_d = 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      clk_q <= 1'b1;
    end else begin
      clk_q <= clk_d;
    end
  end

  // ----------------------------------------
  // Valid and alignment
  // ----------------------------------------
  logic valid_q;
  logic valid_d;
  logic aligned_q;
  logic aligned_d;
  logic phase_q;
  logic phase_d;

  always_comb begin
    valid_d   = valid_q;
    aligned_d = aligned_q;
    phase_d   = phase_q;
    if (edge_any) begin
      phase_d = phase_now;
      if (!enable) begin
        aligned_d = 1'b0;
        valid_d   = 1'b0;
      end else if (!aligned_q) begin
        // Wait for the I slot so the stream starts on I
        aligned_d = is_i_slot(phase_now);
        valid_d   = is_i_slot(phase_now);
      end else if (phase_now == phase_q) begin
        // A lost edge breaks the pairing; only an I may restart it
        aligned_d = is_i_slot(phase_now);
        valid_d   = is_i_slot(phase_now);
      end else begin
        valid_d = 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      valid_q   <= 1'b0;
      aligned_q <= 1'b0;
      phase_q   <= iq_bridge_pkg::PHASE_I;
    end else begin
      valid_q   <= valid_d;
      aligned_q <= aligned_d;
      phase_q   <= phase_d;
    end
  end

  // ----------------------------------------
  // Receive data
  // ----------------------------------------
  // Byte launches with the clock low edge, stands until the next
  logic [WIDTH-1:0] bus_q;
  logic [WIDTH-1:0] bus_d;

  always_comb begin
    bus_d = bus_q;
    if (edge_any && dir_rx) begin
      bus_d = adc_s2_q;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      bus_q <= WIDTH'(iq_bridge_pkg::BUS_RESET_VAL);
    end else begin
      bus_q <= bus_d;
    end
  end

  // ----------------------------------------
  // Transmit data
  // ----------------------------------------
  // Latched as the transfer clock rises, so the byte has settled
  logic [WIDTH-1:0] dac_q;
  logic [WIDTH-1:0] dac_d;

  always_comb begin
    dac_d = dac_q;
    if (!edge_any && !clk_q && !dir_rx && valid_q) begin
      dac_d = bus_s2_q;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      dac_q <= WIDTH'(iq_bridge_pkg::DAC_RESET_VAL);
    end else begin
      dac_q <= dac_d;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign xfer_clk_o      = clk_q;
  assign data_valid_o    = valid_q;
  assign data_bus_o      = bus_q;
  assign data_bus_oe_n_o = {WIDTH{~dir_rx}};
  assign dac_input_bus_o = dac_q;

endmodule

// >>> testbench/iq_bridge_props.sv
// Checker for the sample bus bridge
`timescale 1ns/1ps
module iq_bridge_props (
  input wire logic       sys_clk_i,
  input wire logic       srst_i,
  input wire logic       sample_clk_i,
  input wire logic       direction_rx_i,
  input wire logic       xfer_enable_i,
  input wire logic       xfer_clk_o,
  input wire logic       data_valid_o,
  input wire logic [7:0] data_bus_oe_n_o,
  input wire logic [7:0] dac_input_bus_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (srst_i);
  AST_PULSE: assert property (!xfer_clk_o |=> xfer_clk_o)
    else $error("pulse");
  AST_VCHG: assert property ($changed(data_valid_o) |-> !xfer_clk_o)
    else $error("valid");
  AST_OFF: assert property (!xfer_enable_i [*8] ##0 !xfer_clk_o
    |-> !data_valid_o) else $error("off");
  AST_FIRST: assert property ($rose(data_valid_o) |-> sample_clk_i)
    else $error("first");
  AST_KEEP: assert property (xfer_enable_i [*8] ##0 data_valid_o
    |=> data_valid_o) else $error("keep");
  AST_RX: assert property (direction_rx_i [*4] |-> !(|data_bus_oe_n_o))
    else $error("rx");
  AST_TX: assert property (!direction_rx_i [*4] |-> &data_bus_oe_n_o)
    else $error("tx");
  AST_DAC: assert property ($changed(dac_input_bus_o) |-> !$past(xfer_clk_o))
    else $error("dac");
  cover property (data_valid_o && !xfer_clk_o && !sample_clk_i);
  cover property ($changed(dac_input_bus_o));
  cover property ($rose(data_valid_o));
endmodule
bind iq_sample_bus_bridge iq_bridge_props i_props (.*);

// >>> testbench/iq_port_model.sv
// Peripheral side model of the parallel port
`timescale 1ns/1ps
module iq_port_model (
  input  wire logic       sys_clk_i,
  input  wire logic       xfer_clk_i,
  input  wire logic       dir_rx_i,
  output logic      [7:0] bus_o
);
  logic [7:0] byte_q = 8'h5A;
  logic       prev_q = 1'b1;
  always @(posedge sys_clk_i) begin
    #1 prev_q <= xfer_clk_i;
    if (xfer_clk_i && !prev_q) byte_q <= byte_q + 8'h11;
  end
  // Released bus shows the inverse, never a stale copy
  assign bus_o = dir_rx_i ? ~byte_q : byte_q;
endmodule

// >>> testbench/iq_sample_bus_bridge_tb.sv
// Self-checking bench for the sample bus bridge
`timescale 1ns/1ps
module iq_sample_bus_bridge_tb;
  logic       clk = 0, srst = 1, dir_rx = 1, en = 0, xclk, valid;
  logic [3:0] cnt = 4'h0;
  logic [7:0] bin, dac, bout, oe_n, b;
  int         err_count = 0, n_tests = 0, cyc = 0;
  wire  [7:0] adc = (cnt[3] ^ cnt[2]) ? 8'h3C : 8'hC3;
  always #12.5 clk = ~clk;
  always @(posedge clk) begin
    cnt <= #1 cnt + 4'h1;
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      err_count++;
      close_out();
    end
  end
  iq_sample_bus_bridge i_dut (.sys_clk_i(clk), .srst_i(srst),
    .sample_clk_i(cnt[3]), .adc_output_bus_i(adc), .dac_input_bus_o(dac),
    .direction_rx_i(dir_rx), .xfer_enable_i(en), .xfer_clk_o(xclk),
    .data_valid_o(valid), .data_bus_i(bin), .data_bus_o(bout),
    .data_bus_oe_n_o(oe_n));
  iq_port_model i_port (.sys_clk_i(clk), .xfer_clk_i(xclk),
    .dir_rx_i(dir_rx), .bus_o(bin));
  task automatic chk(string nm, logic [7:0] seen, logic [7:0] ex);
    n_tests++;
    if (seen !== ex) begin
      err_count++;
      $display("MISMATCH %s exp %h seen %h", nm, ex, seen);
    end
  endtask
  task automatic step(); @(posedge clk); #1; endtask
  task automatic xfer(); do step(); while (xclk !== 1'b0); endtask
  task automatic rx_test();
    repeat (2) begin
      xfer();
      chk("idle valid", valid, 8'h00);
    end
    // Enable in the low half after the Q slot has passed: the next I slot opens the stream
    do step(); while (cnt[3]);
    en = 1;
    do xfer(); while (valid !== 1'b1);
    chk("first I", bout, 8'h3C);
    chk("rx oe", oe_n, 8'h00);
    xfer();
    chk("Q byte", bout, 8'hC3);
    chk("Q valid", valid, 8'h01);
  endtask
  task automatic tx_test();
    dir_rx = 0;
    repeat (3) xfer();
    chk("tx oe", oe_n, 8'hFF);
    b = bin;
    repeat (2) step();
    chk("dac", dac, b);
  endtask
  task automatic close_out();
    $display("Checks %0d, mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge clk);
    #1 srst = 0;
    rx_test();
    tx_test();
    close_out();
  end
endmodule
